// *** logic/cief_pkg.sv ***
`default_nettype none
package cief_pkg;
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    localparam int EVT_W = 4;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CORE_CTRL = 8'h0B;
    localparam logic [7:0] IDX_PERIPH_EN = 8'h8C;
    localparam logic [7:0] IDX_EVT_STATUS = 8'h90;
    localparam logic [7:0] IDX_EVT_MASK = 8'h91;
    localparam logic [APB_AW-1:0] ADDR_CORE_CTRL = {2'h0, IDX_CORE_CTRL, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_PERIPH_EN = {2'h0, IDX_PERIPH_EN, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_EVT_STATUS = {2'h0, IDX_EVT_STATUS, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_EVT_MASK = {2'h0, IDX_EVT_MASK, 2'h0};
    localparam logic [7:0] CORE_CTRL_RST = 8'h00;
    localparam logic [7:0] PERIPH_EN_RST = 8'h00;
    localparam logic [7:0] PERIPH_EN_WMASK = 8'h4F;
    localparam logic [EVT_W-1:0] EVT_RST = 4'h0;
    localparam logic [EVT_W-1:0] EVT_WMASK = 4'hF;
    localparam logic [APB_DW-1:0] RDATA_RST = 32'h0000_0000;

    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_group_enable;
        logic timer_zero_overflow_enable;
        logic external_pin_irq_enable;
        logic port_change_irq_enable;
        logic timer_zero_overflow_flag;
        logic external_pin_irq_flag;
        logic port_change_irq_flag;
    } cief_ctrl_t;

    // The peripheral flag input uses this same bit layout.
    typedef struct packed {
        logic unused7;
        logic converter_done_enable;
        logic unused5;
        logic unused4;
        logic serial_port_irq_enable;
        logic capture_compare_irq_enable;
        logic timer_two_match_enable;
        logic timer_one_overflow_enable;
    } cief_pie_t;

    typedef struct packed {
        logic req_rise;
        logic port_chg;
        logic ext_pin;
        logic timer_zero_count_ovf;
    } cief_evt_t;
endpackage
`default_nettype wire

// *** logic/cief_core.sv ***
// Behaviour
// - Peripheral requests need the group enable set.
// - Timer-zero overflow requests only when enabled.
// - External pin flag sets, holds, software clears.
// - Each peripheral source gated by own enable.
// - Converter-done request gated by bit six.
// - Timer-two match request gated by bit one.
// - Flags set regardless of any enable.
`timescale 1ns/1ps
`default_nettype none
module cief_core (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [cief_pkg::APB_AW-1:0] PADDR,
    input wire logic [cief_pkg::APB_DW-1:0] PWDATA,
    output logic [cief_pkg::APB_DW-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TIMER_ZERO_COUNT_OVF,
    input wire logic PORT_CHANGE,
    input wire logic EXT_IRQ_PIN,
    input wire cief_pkg::cief_pie_t PERIPH_FLAGS,
    output logic CORE_IRQ,
    output logic IRQ
);
    import cief_pkg::*;

    function automatic logic addr_hit(
        input logic [APB_AW-1:0] a,
        input logic [APB_AW-1:0] t
    );
        addr_hit = (a == t);
    endfunction

    cief_ctrl_t core_interrupt_control_r;
    cief_ctrl_t core_interrupt_control_nxt;
    cief_pie_t peripheral_interrupt_enable_r;
    cief_pie_t peripheral_interrupt_enable_nxt;
    cief_evt_t evt_status_r;
    cief_evt_t evt_status_nxt;
    cief_evt_t evt_mask_r;
    cief_evt_t evt_now;
    logic [APB_DW-1:0] prdata_r;
    logic [APB_DW-1:0] rd_mux;
    logic ext_meta_r;
    logic ext_sync_r;
    logic ext_prev_r;
    logic ext_evt;
    logic core_irq_r;
    logic irq_req;
    logic periph_req;
    logic [2:0] core_hit;
    cief_pie_t periph_hit;
    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic sel_core;
    logic sel_periph;
    logic sel_status;
    logic sel_mask;
    logic sel_any;

    // The pin is asynchronous; the edge is taken only after two flops.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            ext_meta_r <= EXT_IRQ_PIN;
            ext_sync_r <= ext_meta_r;
            ext_prev_r <= ext_sync_r;
        end
    end

    // Edge polarity selection lives elsewhere; rising edges are used here.
    assign ext_evt = ext_sync_r & ~ext_prev_r;

    assign setup_ph = PSEL & ~PENABLE;
    assign access_ph = PSEL & PENABLE;
    assign wr_en = access_ph & PWRITE;
    assign sel_core = addr_hit(PADDR, ADDR_CORE_CTRL);
    assign sel_periph = addr_hit(PADDR, ADDR_PERIPH_EN);
    assign sel_status = addr_hit(PADDR, ADDR_EVT_STATUS);
    assign sel_mask = addr_hit(PADDR, ADDR_EVT_MASK);
    assign sel_any = sel_core | sel_periph | sel_status | sel_mask;

    // Hardware sets win over a software write in the same cycle.
    always_comb begin
        core_interrupt_control_nxt = core_interrupt_control_r;
        if (wr_en && sel_core) begin
            core_interrupt_control_nxt = cief_ctrl_t'(PWDATA[7:0]);
        end
        if (TIMER_ZERO_COUNT_OVF) begin
            core_interrupt_control_nxt.timer_zero_overflow_flag = 1'b1;
        end
        if (ext_evt) begin
            core_interrupt_control_nxt.external_pin_irq_flag = 1'b1;
        end
        if (PORT_CHANGE) begin
            core_interrupt_control_nxt.port_change_irq_flag = 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            core_interrupt_control_r <= cief_ctrl_t'(CORE_CTRL_RST);
        end else begin
            core_interrupt_control_r <= core_interrupt_control_nxt;
        end
    end

    always_comb begin
        peripheral_interrupt_enable_nxt = peripheral_interrupt_enable_r;
        if (wr_en && sel_periph) begin
            peripheral_interrupt_enable_nxt = cief_pie_t'(PWDATA[7:0] & PERIPH_EN_WMASK);
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            peripheral_interrupt_enable_r <= cief_pie_t'(PERIPH_EN_RST);
        end else begin
            peripheral_interrupt_enable_r <= peripheral_interrupt_enable_nxt;
        end
    end

    // Each peripheral flag meets only its own enable.
    always_comb begin
        periph_hit = cief_pie_t'(PERIPH_FLAGS & peripheral_interrupt_enable_r & PERIPH_EN_WMASK);
        periph_hit.converter_done_enable = PERIPH_FLAGS.converter_done_enable
            & peripheral_interrupt_enable_r.converter_done_enable;
        periph_hit.timer_two_match_enable = PERIPH_FLAGS.timer_two_match_enable
            & peripheral_interrupt_enable_r.timer_two_match_enable;
    end

    assign periph_req = core_interrupt_control_r.peripheral_group_enable & (|periph_hit);

    assign core_hit[2] = core_interrupt_control_r.timer_zero_overflow_flag
        & core_interrupt_control_r.timer_zero_overflow_enable;
    assign core_hit[1] = core_interrupt_control_r.external_pin_irq_flag
        & core_interrupt_control_r.external_pin_irq_enable;
    assign core_hit[0] = core_interrupt_control_r.port_change_irq_flag
        & core_interrupt_control_r.port_change_irq_enable;

    assign irq_req = core_interrupt_control_r.global_irq_enable & ((|core_hit) | periph_req);

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            core_irq_r <= 1'b0;
        end else begin
            core_irq_r <= irq_req;
        end
    end

    assign CORE_IRQ = core_irq_r;

    // Sticky event log for the system interrupt line, cleared by writing ones.
    always_comb begin
        evt_now.req_rise = irq_req & ~core_irq_r;
        evt_now.port_chg = PORT_CHANGE;
        evt_now.ext_pin = ext_evt;
        evt_now.timer_zero_count_ovf = TIMER_ZERO_COUNT_OVF;
    end

    always_comb begin
        evt_status_nxt = evt_status_r;
        if (wr_en && sel_status) begin
            evt_status_nxt = cief_evt_t'(evt_status_r & ~PWDATA[EVT_W-1:0]);
        end
        evt_status_nxt = cief_evt_t'(evt_status_nxt | evt_now);
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            evt_status_r <= cief_evt_t'(EVT_RST);
        end else begin
            evt_status_r <= evt_status_nxt;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            evt_mask_r <= cief_evt_t'(EVT_RST);
        end else if (wr_en && sel_mask) begin
            evt_mask_r <= cief_evt_t'(PWDATA[EVT_W-1:0] & EVT_WMASK);
        end
    end

    assign IRQ = |(evt_status_r & evt_mask_r);

    // Read data is sampled in the setup phase, so a flag that sets during
    // the access phase shows on the next read, never as a torn value.
    always_comb begin
        rd_mux = RDATA_RST;
        if (sel_core) begin
            rd_mux[7:0] = core_interrupt_control_r;
        end
        if (sel_periph) begin
            rd_mux[7:0] = peripheral_interrupt_enable_r;
        end
        if (sel_status) begin
            rd_mux[EVT_W-1:0] = evt_status_r;
        end
        if (sel_mask) begin
            rd_mux[EVT_W-1:0] = evt_mask_r;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            prdata_r <= RDATA_RST;
        end else if (setup_ph && !PWRITE) begin
            prdata_r <= rd_mux;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = 1'b1;
    assign PSLVERR = access_ph & ~sel_any;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);

    sequence pin_rise_s;
        !ext_sync_r ##1 ext_sync_r;
    endsequence

    sequence core_write_s;
        wr_en && sel_core;
    endsequence

    // A software clear of the pin flag only counts when no edge lands with it.
    sequence ext_clear_s;
        core_write_s ##0 (!PWDATA[1] && !ext_evt);
    endsequence

    chk_group_gate_off: assert property (
        (!core_interrupt_control_r.peripheral_group_enable && core_hit == 3'h0
            && !$past(irq_req))
        |=> !CORE_IRQ
    ) else $error("peripheral request passed a cleared group enable");

    chk_timer_zero_gate: assert property (
        (core_interrupt_control_r.global_irq_enable
            && core_interrupt_control_r.timer_zero_overflow_flag
            && core_interrupt_control_r.timer_zero_overflow_enable)
        |=> CORE_IRQ
    ) else $error("enabled timer-zero overflow did not interrupt");

    chk_ext_flag_set: assert property (
        pin_rise_s ##1 !(core_write_s) |=> core_interrupt_control_r.external_pin_irq_flag
    ) else $error("external pin edge did not set its flag");

    chk_ext_flag_hold: assert property (
        (core_interrupt_control_r.external_pin_irq_flag && !(core_write_s))
        |=> core_interrupt_control_r.external_pin_irq_flag
    ) else $error("external pin flag cleared without a write");

    chk_periph_own_gate: assert property (
        (core_hit == 3'h0
            && (PERIPH_FLAGS & peripheral_interrupt_enable_r & PERIPH_EN_WMASK) == 8'h00)
        |=> !CORE_IRQ
    ) else $error("peripheral request without its own enable");

    chk_converter_gate: assert property (
        (core_interrupt_control_r.global_irq_enable
            && core_interrupt_control_r.peripheral_group_enable
            && PERIPH_FLAGS.converter_done_enable
            && peripheral_interrupt_enable_r.converter_done_enable)
        |=> CORE_IRQ
    ) else $error("enabled converter request did not interrupt");

    chk_timer_two_gate: assert property (
        (core_interrupt_control_r.global_irq_enable
            && core_interrupt_control_r.peripheral_group_enable
            && PERIPH_FLAGS.timer_two_match_enable
            && peripheral_interrupt_enable_r.timer_two_match_enable)
        |=> CORE_IRQ
    ) else $error("enabled timer-two match did not interrupt");

    chk_flag_ignores_enable: assert property (
        (TIMER_ZERO_COUNT_OVF && PORT_CHANGE)
        |=> (core_interrupt_control_r.timer_zero_overflow_flag
            && core_interrupt_control_r.port_change_irq_flag)
    ) else $error("flag not set while its enable was clear");

    chk_global_gate: assert property (
        !core_interrupt_control_r.global_irq_enable |=> !CORE_IRQ
    ) else $error("core interrupt raised with global enable clear");

    chk_unmapped_error: assert property (
        (access_ph && !sel_any) |-> (PSLVERR && PREADY)
    ) else $error("unmapped access not answered with an error");

    chk_ext_flag_clear: assert property (
        ext_clear_s |=> !core_interrupt_control_r.external_pin_irq_flag
    ) else $error("external pin flag survived a software clear");

    chk_timer_zero_count_flag_set: assert property (
        TIMER_ZERO_COUNT_OVF |=> core_interrupt_control_r.timer_zero_overflow_flag
    ) else $error("timer-zero overflow did not set its flag");

    chk_port_flag_set: assert property (
        PORT_CHANGE |=> core_interrupt_control_r.port_change_irq_flag
    ) else $error("port change did not set its flag");

    chk_timer_zero_block: assert property (
        (!core_interrupt_control_r.timer_zero_overflow_enable && core_hit[1:0] == 2'h0 && !periph_req)
        |=> !CORE_IRQ
    ) else $error("timer-zero request passed a cleared enable");

    chk_periph_mask_bits: assert property (
        (wr_en && sel_periph) |=> (peripheral_interrupt_enable_r & ~PERIPH_EN_WMASK) == 8'h00
    ) else $error("unimplemented peripheral enable bit was written");

    chk_converter_block: assert property (
        !peripheral_interrupt_enable_r.converter_done_enable |-> !periph_hit.converter_done_enable
    ) else $error("converter request passed a cleared enable");

    chk_timer_two_block: assert property (
        !peripheral_interrupt_enable_r.timer_two_match_enable |-> !periph_hit.timer_two_match_enable
    ) else $error("timer-two match request passed a cleared enable");

    chk_status_clear: assert property (
        (wr_en && sel_status && PWDATA[2] && !PORT_CHANGE) |=> !evt_status_r.port_chg
    ) else $error("event status bit survived a write of one");

    chk_req_rise_log: assert property (
        (irq_req && !core_irq_r) |=> evt_status_r.req_rise
    ) else $error("core request rising edge was not logged");

endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cief_pkg::*;
    logic mclk, sys_rst, psel, penable, pwrite, timer_zero_count_ovf, port_change, ext_pin;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata, q;
    logic pready, pslverr, core_irq, irq, e;
    cief_pie_t pflags;
    logic [15:0] seed;
    int n_fail, n_tests;

    cief_core dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TIMER_ZERO_COUNT_OVF(timer_zero_count_ovf), .PORT_CHANGE(port_change), .EXT_IRQ_PIN(ext_pin),
        .PERIPH_FLAGS(pflags), .CORE_IRQ(core_irq), .IRQ(irq));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected request to the core from the control word, enable word and peripheral flags.
    function automatic logic exp_core(input logic [7:0] c, input logic [7:0] p, input logic [7:0] f);
        logic src;
        src = (c[5] & c[2]) | (c[4] & c[1]) | (c[3] & c[0]) | (c[6] & (|(p & f & 8'h4F)));
        return c[7] & src;
    endfunction

    task automatic print_verdict();
        $display("counts: %0d compared, %0d mismatched", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    // One transfer; an idle edge first keeps strobes from being driven twice in one step.
    task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        chk_bit(pready, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic run_case(input logic [7:0] c, input logic [7:0] p, input logic [7:0] f);
        @(posedge mclk);
        pflags <= f;
        apb(1'b1, ADDR_CORE_CTRL, {24'h0, c});
        apb(1'b1, ADDR_PERIPH_EN, {24'h0, p});
        settle(2);
        chk_bit(core_irq, exp_core(c, p, f));
        apb(1'b0, ADDR_PERIPH_EN, 32'h0);
        chk_word(q, {24'h0, p & 8'h4F});
        chk_bit(e, 1'b0);
        apb(1'b0, ADDR_CORE_CTRL, 32'h0);
        chk_word(q, {24'h0, c});
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        print_verdict();
    end

    initial begin
        {psel, penable, pwrite, timer_zero_count_ovf, port_change, ext_pin} = 6'h00;
        paddr = '0;
        pwdata = '0;
        pflags = '0;
        seed = 16'h0031;
        n_fail = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        apb(1'b0, ADDR_CORE_CTRL, 32'h0);
        chk_word(q, 32'h0);
        apb(1'b0, ADDR_PERIPH_EN, 32'h0);
        chk_word(q, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk_word({q[30:0], e}, 32'h1);
        $display("test reset done");
        run_case(8'h80, 8'hFF, 8'hFF);
        run_case(8'hC0, 8'h40, 8'h40);
        run_case(8'hC0, 8'h02, 8'h02);
        run_case(8'hC0, 8'hBD, 8'h42);
        run_case(8'h84, 8'h00, 8'h00);
        run_case(8'hA4, 8'h00, 8'h00);
        run_case(8'h52, 8'h00, 8'h00);
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            q[15:0] = seed;
            seed = lfsr(seed);
            run_case(q[7:0], q[15:8], seed[7:0]);
        end
        $display("test gating done");
        apb(1'b1, ADDR_CORE_CTRL, 32'h0);
        apb(1'b1, ADDR_EVT_MASK, 32'h0);
        apb(1'b1, ADDR_EVT_STATUS, 32'hF);
        @(posedge mclk);
        timer_zero_count_ovf <= 1'b1;
        port_change <= 1'b1;
        ext_pin <= 1'b1;
        @(posedge mclk);
        timer_zero_count_ovf <= 1'b0;
        port_change <= 1'b0;
        ext_pin <= 1'b0;
        settle(6);
        chk_bit(core_irq, 1'b0);
        apb(1'b0, ADDR_CORE_CTRL, 32'h0);
        chk_word(q, 32'h07);
        apb(1'b0, ADDR_CORE_CTRL, 32'h0);
        chk_word(q, 32'h07);
        apb(1'b1, ADDR_CORE_CTRL, 32'h0);
        apb(1'b0, ADDR_CORE_CTRL, 32'h0);
        chk_word(q, 32'h00);
        apb(1'b0, ADDR_EVT_STATUS, 32'h0);
        chk_word(q, 32'h7);
        $display("test flags done");
        apb(1'b1, ADDR_EVT_MASK, 32'h2);
        settle(1);
        chk_bit(irq, 1'b1);
        apb(1'b1, ADDR_EVT_STATUS, 32'h2);
        settle(1);
        chk_bit(irq, 1'b0);
        apb(1'b1, ADDR_CORE_CTRL, 32'hA4);
        settle(2);
        chk_bit(core_irq, 1'b1);
        apb(1'b0, ADDR_EVT_STATUS, 32'h0);
        chk_word(q, 32'hD);
        apb(1'b1, ADDR_EVT_MASK, 32'h8);
        settle(1);
        chk_bit(irq, 1'b1);
        apb(1'b1, ADDR_EVT_MASK, 32'h0);
        settle(1);
        chk_bit(irq, 1'b0);
        apb(1'b0, ADDR_EVT_MASK, 32'h0);
        chk_word(q, 32'h0);
        $display("test interrupt done");
        print_verdict();
    end
endmodule
`default_nettype wire
